// *** design/cosp_pkg.sv ***
// Constants and types for the CAN output signal packer
package cosp_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 5;
  localparam int NUM_SRC = 8;
  localparam int RATE_MAX = 10000;
  localparam int TIME_UNIT_MS = 1;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = TIME_UNIT_MS * CLK_MHZ * 1000;
  // ----------------------------------------------------------------
  // Reset values and fixed fields
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] POS_RST = 4'h1;
  localparam logic [31:0] RES_RST = 32'h0000_0001;
  localparam logic [31:0] OFS_RST = 32'h0000_0000;
  localparam logic [31:0] MAX_RST = 32'h0000_0001;
  localparam logic [31:0] MIN_RST = 32'h0000_0000;
  localparam logic [13:0] RATE_RST = 14'h0000;
  localparam logic [63:0] FRAME_FILL = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0] GLOBAL_ADDR = 8'hff;
  localparam logic [7:0] PDU2_MIN = 8'hf0;
  localparam logic [7:0] OWN_ADDR_RST = 8'h80;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    COSP_UNDEF = 3'h0,
    COSP_DISC1 = 3'h1,
    COSP_DISC2 = 3'h2,
    COSP_DISC4 = 3'h3,
    COSP_CONT1 = 3'h4,
    COSP_CONT2 = 3'h5,
    COSP_CONT4 = 3'h6
  } cosp_sig_type;
  typedef enum logic [0:0] {
    COSP_IDLE = 1'b0,
    COSP_HOLD = 1'b1
  } cosp_state_type;
endpackage : cosp_pkg

// *** design/cosp_slot.sv ***
// One signal slot: encodes a value and gives its field and mask in the data field
`timescale 1ns/10ps
module cosp_slot
(
  // Slot configuration
  input wire logic [2:0] sig_type,
  input wire logic connected,
  input wire logic invert,
  input wire logic [3:0] pos_byte,
  input wire logic [3:0] pos_bit,
  input wire logic signed [31:0] resolution,
  input wire logic signed [31:0] offset,
  input wire logic signed [31:0] max_val,
  input wire logic signed [31:0] min_val,
  // Selected source value
  input wire logic signed [31:0] value,
  // Placed field
  output logic [63:0] field_data,
  output logic [63:0] field_mask
);
  import cosp_pkg::*;

  // ----------------------------------------------------------------
  // Type decode
  // ----------------------------------------------------------------
  wire is_disc = (sig_type == COSP_DISC1) || (sig_type == COSP_DISC2) || (sig_type == COSP_DISC4);
  wire is_cont = (sig_type == COSP_CONT1) || (sig_type == COSP_CONT2) || (sig_type == COSP_CONT4);
  wire active = connected && (is_disc || is_cont);
  wire [31:0] width_mask = (sig_type == COSP_DISC1) ? 32'h0000_0001 :
                           (sig_type == COSP_DISC2) ? 32'h0000_0003 :
                           (sig_type == COSP_DISC4) ? 32'h0000_000f :
                           (sig_type == COSP_CONT1) ? 32'h0000_00ff :
                           (sig_type == COSP_CONT2) ? 32'h0000_ffff :
                           (sig_type == COSP_CONT4) ? 32'hffff_ffff : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Continuous path
  // ----------------------------------------------------------------
  wire signed [31:0] clamped = (value > max_val) ? max_val : (value < min_val) ? min_val : value;
  wire signed [31:0] mirrored = max_val - (clamped - min_val);
  wire signed [31:0] cont_in = invert ? mirrored : clamped;
  wire signed [31:0] shifted = cont_in - offset;
  wire signed [31:0] safe_res = (resolution == 32'sh0) ? 32'sh1 : resolution;
  wire signed [31:0] cont_code = shifted / safe_res;

  // ----------------------------------------------------------------
  // Discrete path
  // ----------------------------------------------------------------
  wire [31:0] disc_code = invert ? ~value : value;

  // ----------------------------------------------------------------
  // Placement
  // ----------------------------------------------------------------
  wire [2:0] byte_idx = 3'(pos_byte - 4'h1);
  wire [2:0] bit_idx = is_disc ? 3'(pos_bit - 4'h1) : 3'h0;
  wire [5:0] shamt = {byte_idx, bit_idx};
  wire [31:0] code = (is_disc ? disc_code : cont_code) & width_mask;
  wire [63:0] mask_raw = {32'h0, width_mask} << shamt;

  assign field_mask = active ? mask_raw : 64'h0;
  assign field_data = active ? ({32'h0, code} << shamt) : 64'h0;
endmodule : cosp_slot

// *** design/cosp_top.sv ***
// CAN output message packer: slot encoding, frame assembly and send timing
`timescale 1ns/10ps
module cosp_top
#(
  parameter int CYC_PER_MS_P = cosp_pkg::CYC_PER_MS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Logical signal sources
  input wire logic [31:0] src_value [cosp_pkg::NUM_SRC],
  // Slot configuration
  input wire logic [2:0] cfg_type [cosp_pkg::NUM_SLOTS],
  input wire logic [3:0] cfg_src [cosp_pkg::NUM_SLOTS],
  input wire logic cfg_invert [cosp_pkg::NUM_SLOTS],
  input wire logic [3:0] cfg_byte [cosp_pkg::NUM_SLOTS],
  input wire logic [3:0] cfg_bit [cosp_pkg::NUM_SLOTS],
  input wire logic [31:0] cfg_res [cosp_pkg::NUM_SLOTS],
  input wire logic [31:0] cfg_ofs [cosp_pkg::NUM_SLOTS],
  input wire logic [31:0] cfg_max [cosp_pkg::NUM_SLOTS],
  input wire logic [31:0] cfg_min [cosp_pkg::NUM_SLOTS],
  // Message configuration
  input wire logic cfg_tx_en,
  input wire logic [13:0] cfg_rate,
  input wire logic [17:0] cfg_pgn,
  input wire logic tx_request,
  // CAN controller side
  output logic tx_valid_ff,
  input wire logic tx_ready,
  output logic [63:0] tx_data_ff,
  output logic [17:0] tx_pgn_ff,
  output logic [7:0] tx_dest_ff,
  output logic tx_done_ff
);
  import cosp_pkg::*;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic [31:0] sel_value [NUM_SLOTS];
  logic sel_conn [NUM_SLOTS];
  logic [63:0] fld_data [NUM_SLOTS];
  logic [63:0] fld_mask [NUM_SLOTS];
  logic [63:0] stage [NUM_SLOTS+1];

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++)
    begin : g_slot
      wire [3:0] src_idx = cfg_src[g] - 4'h1;
      wire in_range = (cfg_src[g] != SRC_NONE) && (32'(cfg_src[g]) <= NUM_SRC);
      assign sel_conn[g] = in_range;
      assign sel_value[g] = in_range ? src_value[src_idx[2:0]] : 32'h0;

      cosp_slot u_slot
      (
        .sig_type(cfg_type[g]),
        .connected(sel_conn[g]),
        .invert(cfg_invert[g]),
        .pos_byte(cfg_byte[g]),
        .pos_bit(cfg_bit[g]),
        .resolution(cfg_res[g]),
        .offset(cfg_ofs[g]),
        .max_val(cfg_max[g]),
        .min_val(cfg_min[g]),
        .value(sel_value[g]),
        .field_data(fld_data[g]),
        .field_mask(fld_mask[g])
      );

      // Later slots overwrite earlier ones where fields overlap
      assign stage[g+1] = (stage[g] & ~fld_mask[g]) | fld_data[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  assign stage[0] = FRAME_FILL;
  wire [63:0] frame_now = stage[NUM_SLOTS];
  wire pdu1 = cfg_pgn[15:8] < PDU2_MIN;
  wire [17:0] pgn_out = pdu1 ? {cfg_pgn[17:8], 8'h00} : cfg_pgn;
  wire [7:0] dest_out = pdu1 ? GLOBAL_ADDR : cfg_pgn[7:0];

  // ----------------------------------------------------------------
  // Rate timing
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_ff;
  logic [31:0] nxt_ms_cnt;
  logic [13:0] rate_cnt_ff;
  logic [13:0] nxt_rate_cnt;
  logic req_pend_ff;
  logic nxt_req_pend;

  wire [13:0] rate_lim = (32'(cfg_rate) > RATE_MAX) ? 14'(RATE_MAX) : cfg_rate;
  wire periodic = cfg_tx_en && (rate_lim != RATE_RST);
  wire ms_tick = periodic && (ms_cnt_ff == 32'(CYC_PER_MS_P - 1));
  wire period_hit = ms_tick && (rate_cnt_ff == rate_lim - 14'h1);
  wire on_demand = cfg_tx_en && (rate_lim == RATE_RST) && (tx_request || req_pend_ff);

  assign nxt_ms_cnt = (!periodic || ms_tick) ? 32'h0 : ms_cnt_ff + 32'h1;
  assign nxt_rate_cnt = !periodic ? 14'h0 : period_hit ? 14'h0 : ms_tick ? rate_cnt_ff + 14'h1 : rate_cnt_ff;

  // ----------------------------------------------------------------
  // Send control
  // ----------------------------------------------------------------
  cosp_state_type state_ff;
  cosp_state_type nxt_state;
  logic [63:0] nxt_data;
  logic [17:0] nxt_pgn;
  logic [7:0] nxt_dest;

  wire fire = (period_hit || on_demand) && cfg_tx_en;
  wire start = (state_ff == COSP_IDLE) && fire;
  wire accept = (state_ff == COSP_HOLD) && tx_ready;
  wire drop = (state_ff == COSP_HOLD) && !cfg_tx_en;

  // A request seen while a frame is held is sent after it
  assign nxt_req_pend = cfg_tx_en && (rate_lim == RATE_RST) && ((tx_request || req_pend_ff) && !start);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      COSP_IDLE:
      begin
        if (start)
        begin
          nxt_state = COSP_HOLD;
        end
      end
      COSP_HOLD:
      begin
        if (accept || drop)
        begin
          nxt_state = COSP_IDLE;
        end
      end
    endcase
  end

  assign nxt_data = start ? frame_now : tx_data_ff;
  assign nxt_pgn = start ? pgn_out : tx_pgn_ff;
  assign nxt_dest = start ? dest_out : tx_dest_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff <= COSP_IDLE;
      ms_cnt_ff <= 32'h0;
      rate_cnt_ff <= 14'h0;
      req_pend_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_done_ff <= 1'b0;
      tx_data_ff <= FRAME_FILL;
      tx_pgn_ff <= 18'h0;
      tx_dest_ff <= GLOBAL_ADDR;
    end
    else
    begin
      state_ff <= nxt_state;
      ms_cnt_ff <= nxt_ms_cnt;
      rate_cnt_ff <= nxt_rate_cnt;
      req_pend_ff <= nxt_req_pend;
      tx_valid_ff <= (nxt_state == COSP_HOLD);
      tx_done_ff <= accept;
      tx_data_ff <= nxt_data;
      tx_pgn_ff <= nxt_pgn;
      tx_dest_ff <= nxt_dest;
    end
  end
endmodule : cosp_top

// *** verif/cosp_sva.sv ***
// Port checker for the CAN output packer
`timescale 1ns/10ps
module cosp_sva
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic cfg_tx_en,
  input wire logic [13:0] cfg_rate,
  input wire logic tx_request,
  input wire logic tx_valid_ff,
  input wire logic tx_ready,
  input wire logic [63:0] tx_data_ff,
  input wire logic [17:0] tx_pgn_ff,
  input wire logic [7:0] tx_dest_ff,
  input wire logic tx_done_ff
);
  import cosp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire pdu1 = tx_pgn_ff[15:8] < PDU2_MIN;
  a_take_done: assert property (tx_valid_ff && tx_ready |=> tx_done_ff && !tx_valid_ff)
    else $error("no done after take");
  a_done_pulse: assert property (tx_done_ff |=> !tx_done_ff)
    else $error("done too long");
  a_hold_frame: assert property (tx_valid_ff && !tx_ready && cfg_tx_en |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("held frame moved");
  a_en_gate: assert property (!cfg_tx_en |=> !tx_valid_ff)
    else $error("frame while disabled");
  a_rise_enabled: assert property ($rose(tx_valid_ff) |-> $past(cfg_tx_en))
    else $error("frame started disabled");
  a_req_start: assert property (cfg_tx_en && cfg_rate == 14'h0 && tx_request && !tx_valid_ff && !tx_done_ff
    |=> tx_valid_ff)
    else $error("request not answered");
  a_global_dest: assert property (tx_valid_ff && pdu1 |-> tx_dest_ff == GLOBAL_ADDR && tx_pgn_ff[7:0] == 8'h00)
    else $error("bad global dest");
  a_pdu2_dest: assert property (tx_valid_ff && !pdu1 |-> tx_dest_ff == tx_pgn_ff[7:0])
    else $error("bad dest");
  c_take: cover property (tx_valid_ff && tx_ready);
  c_stall: cover property ((tx_valid_ff && !tx_ready) [*3]);
  c_periodic: cover property ($rose(tx_valid_ff) && cfg_rate != 14'h0);
endmodule : cosp_sva

// *** verif/cosp_ctrl_model.sv ***
// Behavioural CAN controller taking frames after a set stall
`timescale 1ns/10ps
module cosp_ctrl_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frame offer
  input wire logic tx_valid_ff,
  input wire logic [63:0] tx_data_ff,
  output logic tx_ready,
  // Stall setting and record
  input wire logic [7:0] stall,
  output logic [63:0] got_data,
  output logic [7:0] got_cnt
);
  logic [7:0] wait_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      got_cnt <= 8'h00;
    if (!rst_b || !tx_valid_ff)
    begin
      tx_ready <= 1'b0;
      wait_ff <= 8'h00;
    end
    else if (tx_ready)
    begin
      tx_ready <= 1'b0;
      got_data <= tx_data_ff;
      got_cnt <= got_cnt + 8'h01;
    end
    else
    begin
      wait_ff <= wait_ff + 8'h01;
      tx_ready <= wait_ff >= stall;
    end
  end
endmodule : cosp_ctrl_model

// *** verif/cosp_top_tb.sv ***
// Testbench for the CAN output packer
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cosp_top_tb;
  import cosp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] src [NUM_SRC];
  logic [2:0] typ [NUM_SLOTS];
  logic [3:0] sel [NUM_SLOTS];
  logic inv [NUM_SLOTS];
  logic [3:0] pby [NUM_SLOTS];
  logic [3:0] pbi [NUM_SLOTS];
  logic [31:0] res [NUM_SLOTS];
  logic [31:0] ofs [NUM_SLOTS];
  logic [31:0] mx [NUM_SLOTS];
  logic [31:0] mn [NUM_SLOTS];
  logic en = 1'b0;
  logic [13:0] rate = 14'h0;
  logic [17:0] pgn = 18'h0ef00;
  logic req = 1'b0;
  logic [7:0] stall = 8'h00;
  logic rdy, vld, done;
  logic [63:0] dat, gdat, want;
  logic [17:0] opgn;
  logic [7:0] dst, gcnt;
  int n_mismatch = 0;
  int checks_done = 0;
  int k;
  always #5 clk = ~clk;
  cosp_top #(.CYC_PER_MS_P(10)) dut_u (.clk(clk), .rst_b(rst_b), .src_value(src), .cfg_type(typ),
    .cfg_src(sel), .cfg_invert(inv), .cfg_byte(pby), .cfg_bit(pbi), .cfg_res(res), .cfg_ofs(ofs),
    .cfg_max(mx), .cfg_min(mn), .cfg_tx_en(en), .cfg_rate(rate), .cfg_pgn(pgn), .tx_request(req),
    .tx_valid_ff(vld), .tx_ready(rdy), .tx_data_ff(dat), .tx_pgn_ff(opgn), .tx_dest_ff(dst), .tx_done_ff(done));
  cosp_ctrl_model ctrl_u (.clk(clk), .rst_b(rst_b), .tx_valid_ff(vld), .tx_data_ff(dat), .tx_ready(rdy),
    .stall(stall), .got_data(gdat), .got_cnt(gcnt));
  task automatic slot(input int i, input logic [2:0] t, input logic [3:0] s, input logic v,
    input logic [3:0] by, input logic [3:0] bi, input logic [31:0] r = 32'h1, input logic [31:0] o = 32'h0,
    input logic [31:0] hi = 32'h1, input logic [31:0] lo = 32'h0);
    typ[i] = t; sel[i] = s; inv[i] = v; pby[i] = by; pbi[i] = bi;
    res[i] = r; ofs[i] = o; mx[i] = hi; mn[i] = lo;
  endtask : slot
  task automatic wait_got(output int w);
    logic [7:0] n0;
    n0 = gcnt;
    for (w = 0; w < 200 && gcnt === n0; w++)
      @(negedge clk);
  endtask : wait_got
  task automatic pulse();
    @(negedge clk);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask : pulse
  task automatic frame(input logic [7:0] d, input logic [17:0] p);
    int w;
    pulse();
    `CHK(vld, 1'b1)
    `CHK(dst, d)
    `CHK(opgn, p)
    wait_got(w);
    `CHK(done, 1'b1)
  endtask : frame
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #100us;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    for (k = 0; k < NUM_SRC; k++)
      src[k] = 32'h0;
    for (k = 0; k < NUM_SLOTS; k++)
      slot(k, COSP_UNDEF, SRC_NONE, 1'b0, POS_RST, POS_RST);
    repeat (8) @(negedge clk);
    `CHK(dat, FRAME_FILL)
    rst_b = 1'b1;
    pulse();
    repeat (20) @(negedge clk);
    `CHK(vld, 1'b0)
    en = 1'b1;
    frame(8'hff, 18'h0ef00);
    `CHK(gdat, FRAME_FILL)
    src[0] = 32'h2; src[1] = 32'h1; src[2] = 32'ha;
    slot(0, COSP_DISC2, 4'h1, 1'b0, 4'h3, 4'h4);
    slot(1, COSP_DISC1, 4'h2, 1'b1, 4'h8, 4'h8);
    slot(2, COSP_DISC4, 4'h3, 1'b0, 4'h1, 4'h1);
    slot(3, COSP_UNDEF, 4'h1, 1'b0, 4'h6, 4'h1);
    slot(4, COSP_DISC4, SRC_NONE, 1'b0, 4'h2, 4'h1);
    pgn = 18'h0fe12;
    want = FRAME_FILL; want[20:19] = 2'b10; want[63] = 1'b0; want[3:0] = 4'ha;
    frame(8'h12, 18'h0fe12);
    `CHK(gdat, want)
    src[0] = 32'h1;
    want[20:19] = 2'b01;
    frame(8'h12, 18'h0fe12);
    `CHK(gdat, want)
    for (k = 3; k < NUM_SLOTS; k++)
      slot(k, COSP_UNDEF, SRC_NONE, 1'b0, POS_RST, POS_RST);
    src[3] = 32'h3e8; src[4] = 32'h12c; src[5] = 32'h1e;
    slot(0, COSP_CONT2, 4'h4, 1'b0, 4'h2, 4'h5, 32'ha, 32'h0, 32'h7d0, 32'h0);
    slot(1, COSP_CONT1, 4'h5, 1'b0, 4'h5, 4'h1, 32'h1, 32'h32, 32'hc8, 32'h0);
    slot(2, COSP_CONT4, 4'h6, 1'b1, 4'h8, 4'h1, 32'h3, 32'h0, 32'h6e, 32'ha);
    pgn = 18'h0ef34;
    stall = 8'h06;
    want = FRAME_FILL; want[23:8] = 16'h0064; want[39:32] = 8'h96; want[63:56] = 8'h1e;
    frame(8'hff, 18'h0ef00);
    `CHK(gdat, want)
    stall = 8'h28;
    pulse();
    repeat (3) @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    `CHK(vld, 1'b0)
    en = 1'b1;
    stall = 8'h00;
    rate = 14'h2;
    wait_got(k);
    wait_got(k);
    `CHK(k, 20)
    complete_run();
  end
endmodule : cosp_top_tb
bind cosp_top cosp_sva chk_u (.clk(clk), .rst_b(rst_b), .cfg_tx_en(cfg_tx_en), .cfg_rate(cfg_rate),
  .tx_request(tx_request), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready), .tx_data_ff(tx_data_ff),
  .tx_pgn_ff(tx_pgn_ff), .tx_dest_ff(tx_dest_ff), .tx_done_ff(tx_done_ff));
